// [hdl/gap_write_decoder.sv]
// Gap write decoder with its write command FIFO.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Synchronous FIFO with valid/ready on both sides.
// ------------------------------------------------------------------
module gap_cmd_fifo #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Power-of-two depth keeps pointer wrap free.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2.");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];  // Storage array.
  logic [AW:0]      wr_ptr_r;       // Write pointer with wrap bit.
  logic [AW:0]      rd_ptr_r;       // Read pointer with wrap bit.
  logic             full;           // No free entry.
  logic             empty;          // No stored entry.

  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  // Write pointer and storage.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      wr_ptr_r <= '0;
    else if (in_valid && !full)
    begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
      wr_ptr_r                <= wr_ptr_r + 1'b1;
    end
  end

  // Read pointer.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rd_ptr_r <= '0;
    else if (out_ready && !empty)
      rd_ptr_r <= rd_ptr_r + 1'b1;
  end

endmodule : gap_cmd_fifo

// ------------------------------------------------------------------
// Top: field clock and gap sampling, symbol decode, frame assembly.
// ------------------------------------------------------------------
module gap_write_decoder
  import gap_write_pkg::*;
#(
  parameter int unsigned ID_WIDTH = 64,
  parameter logic [63:0] ID_CODE  = 64'h0123_4567_89ab_cdef  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic  sys_clk,
  input  wire logic  reset,
  // Front end: recovered field clock and gap detector.
  input  wire logic  field_clk,
  input  wire logic  gap_det,
  // Uplink modulation bit for read mode.
  output logic       mod_out,
  // Write commands to nonvolatile memory.
  output logic       prog_valid,
  input  wire logic  prog_ready,
  output write_cmd_t prog_cmd,
  // Status.
  output logic       write_mode,
  output logic       frame_err,
  output logic       frame_ok
);

  if (ID_WIDTH < 1 || ID_WIDTH > 64)
  begin : g_bad_id
    $error("ID_WIDTH must lie from 1 through 64.");
  end

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  logic [1:0] fclk_sync_r;   // Field clock, two stages.
  logic [1:0] gap_sync_r;    // Gap detector, two stages.
  logic       fclk_prev_r;   // Previous synchronised field clock.
  logic       gap_prev_r;    // Previous synchronised gap level.
  logic       fclk_rise;     // One field clock period seen.
  logic       gap_start;     // Leading edge of a detected gap.

  // Both pins are asynchronous; only the second stage feeds logic.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      fclk_sync_r <= 2'h0;
      gap_sync_r  <= 2'h0;
      fclk_prev_r <= 1'b0;
      gap_prev_r  <= 1'b0;
    end
    else
    begin
      fclk_sync_r <= {fclk_sync_r[0], field_clk};
      gap_sync_r  <= {gap_sync_r[0], gap_det};
      fclk_prev_r <= fclk_sync_r[1];
      gap_prev_r  <= gap_sync_r[1];
    end
  end

  assign fclk_rise = fclk_sync_r[1] && !fclk_prev_r;
  assign gap_start = gap_sync_r[1] && !gap_prev_r;

  // ----------------------------------------------------------------
  // Inter-gap counter.
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_r;   // Field clocks since the last gap.
  logic             armed_r; // A start gap has been seen.

  // Counts every pulse the device sees, including those during field
  // decay, so the windows apply to internal counts.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cnt_r <= '0;
    else if (gap_start)
      cnt_r <= '0;
    else if (fclk_rise && cnt_r != CNT_SAT)
      cnt_r <= cnt_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // Symbol decode.
  // ----------------------------------------------------------------
  logic sym_zero;  // Interval in the zero window.
  logic sym_one;   // Interval in the one window.

  assign sym_zero = (cnt_r >= CNT_W'(ZERO_MIN)) && (cnt_r <= CNT_W'(ZERO_MAX));
  assign sym_one  = (cnt_r >= CNT_W'(ONE_MIN)) && (cnt_r <= CNT_W'(ONE_MAX));

  // ----------------------------------------------------------------
  // Frame assembly.
  // ----------------------------------------------------------------
  mode_t                   mode_r;    // Read or write mode.
  logic [BIT_CNT_W-1:0]    nbits_r;   // Bits taken this frame.
  logic [FRAME_BITS-1:0]   shift_r;   // Frame bits, first in at top.
  logic                    err_r;     // Error pulse.
  logic                    ok_r;      // Commit pulse.
  logic                    fifo_in_ready;
  logic                    sym_bit;
  logic                    sym_err;

  assign sym_bit = sym_one;
  assign sym_err = !(sym_zero || sym_one);

  // The first gap arms the decoder; each later gap closes a symbol.
  // A gap with a full frame already held ends the frame: the extra
  // bit makes the count wrong, so it is an error, not a commit.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_r  <= MODE_READ;
      armed_r <= 1'b0;
      nbits_r <= '0;
      shift_r <= '0;
      err_r   <= 1'b0;
    end
    else
    begin
      err_r <= 1'b0;
      if (gap_start)
      begin
        if (!armed_r)
        begin
          // Start gap: open a fresh frame.
          armed_r <= 1'b1;
          mode_r  <= MODE_WRITE;
          nbits_r <= '0;
        end
        else if (sym_err || nbits_r == BIT_CNT_W'(FRAME_BITS))
        begin
          // Bad interval or overlong frame: drop everything.
          armed_r <= 1'b0;
          mode_r  <= MODE_READ;
          nbits_r <= '0;
          err_r   <= 1'b1;
        end
        else if (nbits_r == BIT_CNT_W'(1) && !(shift_r[0] == WRITE_OPCODE[1] && sym_bit == WRITE_OPCODE[0]))
        begin
          // Wrong op-code means this is no write frame.
          armed_r <= 1'b0;
          mode_r  <= MODE_READ;
          nbits_r <= '0;
          err_r   <= 1'b1;
        end
        else
        begin
          shift_r <= {shift_r[FRAME_BITS-2:0], sym_bit};
          nbits_r <= nbits_r + 1'b1;
        end
      end
      else if (armed_r && cnt_r == CNT_SAT && nbits_r != BIT_CNT_W'(FRAME_BITS))
      begin
        // Silence before the frame is complete: the interval can never
        // reach a window, so drop the frame and go back to read.
        armed_r <= 1'b0;
        mode_r  <= MODE_READ;
        nbits_r <= '0;
        err_r   <= 1'b1;
      end
      else if (ok_r)
      begin
        // Frame committed, back to read mode.
        armed_r <= 1'b0;
        mode_r  <= MODE_READ;
        nbits_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Commit: the last gap of a frame is followed by silence. Once the
  // counter saturates with exactly FRAME_BITS held, the frame is done.
  // A reader that keeps gapping instead gets the error path above.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      ok_r <= 1'b0;
    else
      ok_r <= armed_r && !ok_r && !gap_start && cnt_r == CNT_SAT
              && nbits_r == BIT_CNT_W'(FRAME_BITS);
  end

  // ----------------------------------------------------------------
  // Command buffer toward memory.
  // ----------------------------------------------------------------
  write_cmd_t fifo_in;   // Data word and block from the frame.
  write_cmd_t fifo_out;  // Head of the buffer.
  logic       fifo_valid;
  logic       fifo_full_drop; // Commit met a full buffer.

  assign fifo_in.data  = shift_r[ADDR_BITS +: DATA_BITS];
  assign fifo_in.block = shift_r[ADDR_BITS-1:0];
  assign fifo_full_drop = ok_r && !fifo_in_ready;

  gap_cmd_fifo #(
    .WIDTH ($bits(write_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (ok_r),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_valid),
    .out_ready (prog_ready && prog_valid),
    .out_data  (fifo_out)
  );

  // Registered view of the head; the FIFO pops when memory takes it.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      prog_valid <= 1'b0;
      prog_cmd   <= '0;
    end
    else if (!prog_valid || prog_ready)
    begin
      prog_valid <= fifo_valid && !(prog_valid && prog_ready);
      prog_cmd   <= fifo_out;
    end
  end

  // ----------------------------------------------------------------
  // Read mode: identification shifted out endlessly.
  // ----------------------------------------------------------------
  logic [5:0] id_idx_r;  // Current identification bit.

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      id_idx_r <= 6'h00;
      mod_out  <= 1'b0;
    end
    else if (mode_r == MODE_WRITE)
      mod_out <= 1'b0;  // Stay quiet while receiving.
    else if (fclk_rise)
    begin
      mod_out  <= ID_CODE[id_idx_r];
      id_idx_r <= (id_idx_r == 6'(ID_WIDTH - 1)) ? 6'h00 : id_idx_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs, all registered.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      write_mode <= 1'b0;
      frame_err  <= 1'b0;
      frame_ok   <= 1'b0;
    end
    else
    begin
      write_mode <= (mode_r == MODE_WRITE);
      frame_err  <= err_r || fifo_full_drop;
      frame_ok   <= ok_r && fifo_in_ready;
    end
  end

endmodule : gap_write_decoder

// [hdl/gap_write_pkg.sv]
// Constants and carrier types for the gap write decoder.
package gap_write_pkg;

  // ----------------------------------------------------------------
  // Symbol windows, in counted field clock periods.
  // ----------------------------------------------------------------
  localparam int unsigned ZERO_MIN      = 16;  // Shortest interval decoded as a zero.
  localparam int unsigned ZERO_MAX      = 32;  // Longest interval decoded as a zero.
  localparam int unsigned ONE_MIN       = 48;  // Shortest interval decoded as a one.
  localparam int unsigned ONE_MAX       = 64;  // Longest interval decoded as a one.
  localparam int unsigned CNT_W         = 7;   // Counter width, holds ONE_MAX + 1.
  localparam logic [6:0]  CNT_SAT       = 7'h41; // Saturation value, just above ONE_MAX.

  // ----------------------------------------------------------------
  // Frame layout.
  // ----------------------------------------------------------------
  localparam logic [1:0]  WRITE_OPCODE  = 2'h2;  // Binary one-zero.
  localparam int unsigned OPCODE_BITS   = 2;
  localparam int unsigned DATA_BITS     = 32;
  localparam int unsigned ADDR_BITS     = 4;
  localparam int unsigned FRAME_BITS    = OPCODE_BITS + DATA_BITS + ADDR_BITS;
  localparam int unsigned BIT_CNT_W     = 6;   // Holds FRAME_BITS.
  localparam int unsigned FIFO_DEPTH    = 8;   // Write command buffer depth.

  // ----------------------------------------------------------------
  // Carrier types.
  // ----------------------------------------------------------------
  // One committed write: data word and target block.
  typedef struct packed {
    logic [3:0]  block;
    logic [31:0] data;
  } write_cmd_t;

  // Operating mode of the transponder.
  typedef enum logic {MODE_READ, MODE_WRITE} mode_t;

endpackage : gap_write_pkg

// [tb/gap_write_sva.sv]
// Port checker for the gap write decoder.
`timescale 1ns/1ps
module gap_write_sva
  import gap_write_pkg::*;
(
  // Clock and reset.
  input wire logic       sys_clk,
  input wire logic       reset,
  // Observed ports.
  input wire logic       gap_det,
  input wire logic       mod_out,
  input wire logic       prog_valid,
  input wire logic       prog_ready,
  input wire write_cmd_t prog_cmd,
  input wire logic       write_mode,
  input wire logic       frame_err,
  input wire logic       frame_ok
);
  // --------
  // One clock domain, so clocking and reset are set once.
  // --------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_err_ends_write: assert property (frame_err |-> ##[0:2] !write_mode)
    else $error("write mode kept after an error");
  a_one_verdict: assert property (!(frame_err && frame_ok))
    else $error("error and commit together");
  a_ok_pulse_once: assert property (frame_ok |=> !frame_ok)
    else $error("commit pulse too long");
  a_err_pulse_once: assert property (frame_err |=> !frame_err)
    else $error("error pulse too long");
  a_ok_gives_cmd: assert property (frame_ok |-> ##[0:4] prog_valid)
    else $error("commit without a command");
  a_cmd_held_still: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_cmd))
    else $error("command changed while stalled");
  a_ok_ends_write: assert property (frame_ok |=> !write_mode)
    else $error("write mode kept after commit");
  a_write_mutes_id: assert property (write_mode && $past(write_mode) |-> !mod_out)
    else $error("identification sent in write mode");
  // The start gap must open write mode within a few cycles of synchroniser delay.
  a_gap_opens_write: assert property ($rose(gap_det) && !write_mode |-> ##[1:8] write_mode)
    else $error("start gap ignored");
endmodule : gap_write_sva

// [tb/gap_reader_model.sv]
// Base station model: free carrier clock and field gaps.
`timescale 1ns/1ps
module gap_reader_model
(
  // Field side.
  output logic field_clk,
  output logic gap_det
);
  // Intervals sit four counts above each window minimum so synchroniser jitter stays harmless.
  localparam int ZERO_IV = 20;
  localparam int ONE_IV  = 52;

  initial
  begin
    field_clk = 1'b0;
    gap_det = 1'b0;
  end

  // The carrier runs free, since it also powers the device.
  always #40 field_clk = ~field_clk;

  // One gap, held for two carrier periods.
  task automatic gap();
    gap_det = 1'b1;
    repeat (2) @(posedge field_clk);
    gap_det = 1'b0;
  endtask : gap

  // Rest of an interval between gap starts.
  task automatic space(input int n);
    repeat (n - 2) @(posedge field_clk);
  endtask : space

  // Start gap, n bits MSB first, optional bad interval, then silence.
  task automatic send(input logic [38:0] bits, input int n, input int bad);
    @(posedge field_clk);
    gap();
    for (int i = n - 1; i >= 0; i--)
    begin
      space(bits[i] ? ONE_IV : ZERO_IV);
      gap();
    end
    if (bad != 0)
    begin
      space(bad);
      gap();
    end
    space(72);
  endtask : send
endmodule : gap_reader_model

// [tb/tb.sv]
// Self-checking testbench for the gap write decoder.
`timescale 1ns/1ps
module tb
  import gap_write_pkg::*;
;
  logic       sys_clk    = 1'b0; // System clock.
  logic       reset      = 1'b1; // Reset, held three cycles.
  logic       prog_ready = 1'b0; // Memory accepts commands.
  logic       field_clk, gap_det, mod_out, prog_valid, write_mode, frame_err, frame_ok;
  write_cmd_t prog_cmd;          // Command to memory.
  write_cmd_t got[$];            // Commands taken by memory.
  logic       wm_seen    = 1'b0; // Write mode was entered.
  int         fails = 0, comparisons = 0, n_ok = 0, n_err = 0, cycles = 0;

  always #5 sys_clk = ~sys_clk;

  gap_write_decoder DUT (.sys_clk(sys_clk), .reset(reset), .field_clk(field_clk), .gap_det(gap_det),
    .mod_out(mod_out), .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_cmd(prog_cmd),
    .write_mode(write_mode), .frame_err(frame_err), .frame_ok(frame_ok));
  gap_reader_model u_rdr (.field_clk(field_clk), .gap_det(gap_det));

  // Pulses are counted here so no task can miss one; also cuts a hang.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (frame_ok === 1'b1) n_ok++;
    if (frame_err === 1'b1) n_err++;
    if (write_mode === 1'b1) wm_seen = 1'b1;
    if (prog_valid === 1'b1 && prog_ready === 1'b1) got.push_back(prog_cmd);
    if (cycles == 100000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Quiet outputs after reset; identification streams in read mode.
  task automatic t_idle();
    int   flips;
    logic last;
    flips = 0;
    #1 check({write_mode, prog_valid, frame_ok, frame_err}, 4'h0);
    last = mod_out;
    repeat (800)
    begin
      @(posedge sys_clk);
      if (mod_out !== last) flips++;
      last = mod_out;
    end
    check(flips != 0, 1);
  endtask : t_idle

  // One full frame with ready memory.
  task automatic t_good();
    int ok0;
    ok0 = n_ok;
    @(posedge sys_clk) prog_ready <= 1'b1;
    u_rdr.send({1'b0, WRITE_OPCODE, 32'hc35a_96e1, 4'h9}, 38, 0);
    repeat (20) @(posedge sys_clk);
    check(n_ok - ok0, 1);
    check(wm_seen, 1);
    check(got.size(), 1);
    check(got.pop_front(), {4'h9, 32'hc35a_96e1});
  endtask : t_good

  // Intervals outside both windows, then a wrong op-code.
  task automatic t_bad();
    int ivs[2] = '{40, 8};
    int e0;
    foreach (ivs[k])
    begin
      e0 = n_err;
      u_rdr.send(39'h1, 1, ivs[k]);
      check(n_err - e0, 1);
      check(write_mode, 0);
    end
    e0 = n_err;
    u_rdr.send(39'h1, 2, 0);
    check(n_err - e0, 1);
    check(got.size(), 0);
  endtask : t_bad

  // One bit short and one bit long are never programmed.
  task automatic t_length();
    int ok0;
    int e0;
    ok0 = n_ok;
    e0 = n_err;
    u_rdr.send(39'h1 << 36, 37, 0);
    check(n_ok - ok0, 0);
    check(n_err - e0, 1);
    check(write_mode, 0);
    e0 = n_err;
    u_rdr.send(39'h1 << 38, 39, 0);
    check(n_err - e0, 1);
    check(n_ok - ok0, 0);
    check(got.size(), 0);
  endtask : t_length

  // Memory stalls while one frame more than the buffer holds arrives.
  task automatic t_fifo();
    int ok0;
    int e0;
    ok0 = n_ok;
    e0 = n_err;
    @(posedge sys_clk) prog_ready <= 1'b0;
    for (int k = 0; k <= FIFO_DEPTH; k++)
      u_rdr.send({1'b0, WRITE_OPCODE, 32'(k), 4'(k)}, 38, 0);
    check(n_ok - ok0, FIFO_DEPTH);
    check(n_err - e0, 1);
    check(prog_valid, 1);
    @(posedge sys_clk) prog_ready <= 1'b1;
    repeat (30) @(posedge sys_clk);
    check(prog_valid, 0);
    check(got.size(), FIFO_DEPTH);
    for (int k = 0; k < FIFO_DEPTH; k++)
      check(got.pop_front(), {4'(k), 32'(k)});
  endtask : t_fifo

  task automatic final_report();
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_idle();
    t_good();
    t_bad();
    t_length();
    t_fifo();
    final_report();
  end
endmodule : tb

bind gap_write_decoder gap_write_sva u_sva (.sys_clk(sys_clk), .reset(reset), .gap_det(gap_det),
  .mod_out(mod_out), .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_cmd(prog_cmd),
  .write_mode(write_mode), .frame_err(frame_err), .frame_ok(frame_ok));
